// ==== rtl/psl_led_driver.sv ====
// module: active-low status indicator outputs of the phy
`timescale 1ns/1ps
`default_nettype none
module psl_led_driver #(
    parameter int unsigned STRETCH_CYCLES = psl_pkg::STRETCH_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic tx_active,
    input  wire logic crs_active,
    input  wire logic link_good,
    input  wire logic polarity_good,
    input  wire logic full_duplex,
    input  wire logic speed_100,
    input  wire logic collision_active,
    input  wire logic tx_indicator_remap,
    input  wire logic duplex_indicator_remap,
    input  wire logic disconnect_state,
    output var  logic tx_activity_indicator_n,
    output var  logic rx_activity_indicator_n,
    output var  logic link_good_indicator_n,
    output var  logic polarity_duplex_indicator_n,
    output var  logic collision_indicator_n
);
    import psl_pkg::*;

    logic tx_on;
    logic rx_on;
    logic [4:0] ind_reg;
    logic [4:0] ind_next;

    // ----------------------------------------
    // activity stretchers
    // ----------------------------------------
    psl_stretch #(.CW(STRETCH_W), .CYCLES(STRETCH_CYCLES)) u_tx_stretch (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .act   (tx_active),
        .on    (tx_on)
    );
    psl_stretch #(.CW(STRETCH_W), .CYCLES(STRETCH_CYCLES)) u_rx_stretch (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .act   (crs_active),
        .on    (rx_on)
    );

    // ----------------------------------------
    // indicator selection, bit order tx rx link pol col (4..0), all active low
    // ----------------------------------------
    always_comb begin
        // remap bypasses the stretcher: disconnect is a steady level, not a pulse
        ind_next[4] = tx_indicator_remap ? !disconnect_state : !tx_on;
        ind_next[3] = !rx_on;
        ind_next[2] = !link_good;
        if (duplex_indicator_remap || speed_100) begin
            ind_next[1] = !full_duplex;
        end else begin
            ind_next[1] = !polarity_good;
        end
        // left raw in full duplex; the monitor must disregard it then
        ind_next[0] = !collision_active;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ind_reg <= IND_RESET_VALUE;
        end else if (ce) begin
            ind_reg <= ind_next;
        end
    end

    assign tx_activity_indicator_n     = ind_reg[4];
    assign rx_activity_indicator_n     = ind_reg[3];
    assign link_good_indicator_n       = ind_reg[2];
    assign polarity_duplex_indicator_n = ind_reg[1];
    assign collision_indicator_n       = ind_reg[0];

    // ----------------------------------------
    // check helpers: enabled cycles since the last activity sample
    // ----------------------------------------
    // saturating, one bit wider than the stretcher so the end of the hold is visible
    localparam int unsigned       IDLE_W    = STRETCH_W + 1;
    localparam logic [IDLE_W-1:0] HOLD_LAST = IDLE_W'(STRETCH_CYCLES);

    logic [IDLE_W-1:0] tx_idle_reg;
    logic [IDLE_W-1:0] tx_idle_next;
    logic              tx_remap_seen_reg;
    logic              tx_remap_seen_next;
    logic [IDLE_W-1:0] rx_idle_reg;
    logic [IDLE_W-1:0] rx_idle_next;

    always_comb begin
        tx_idle_next       = tx_idle_reg;
        // the tx output uses the remap bit seen at the edge that loaded it
        tx_remap_seen_next = tx_indicator_remap;
        if (tx_active) begin
            tx_idle_next = '0;
        end else if (tx_idle_reg != '1) begin
            tx_idle_next = tx_idle_reg + IDLE_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        // reset starts saturated: outputs are off as after a long idle
        if (!rst_n) begin
            tx_idle_reg       <= '1;
            tx_remap_seen_reg <= 1'b0;
        end else if (ce) begin
            tx_idle_reg       <= tx_idle_next;
            tx_remap_seen_reg <= tx_remap_seen_next;
        end
    end

    always_comb begin
        rx_idle_next = rx_idle_reg;
        if (crs_active) begin
            rx_idle_next = '0;
        end else if (rx_idle_reg != '1) begin
            rx_idle_next = rx_idle_reg + IDLE_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_idle_reg <= '1;
        end else if (ce) begin
            rx_idle_reg <= rx_idle_next;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    tx_active_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && tx_active && !tx_indicator_remap) ##1 (ce && !tx_indicator_remap)
        |=> !tx_activity_indicator_n)
        else $error("tx indicator not low during transmit");
    tx_remap_disc_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && tx_indicator_remap) |=> (tx_activity_indicator_n == !$past(disconnect_state)))
        else $error("tx indicator not showing disconnect state");
    rx_stretch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && $past(ce) && $fell(crs_active)) ##1 ce |=> !rx_activity_indicator_n)
        else $error("rx indicator not stretched after carrier ends");
    rx_active_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && crs_active) ##1 ce |=> !rx_activity_indicator_n)
        else $error("rx indicator not low during carrier");
    link_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce |=> (link_good_indicator_n == !$past(link_good)))
        else $error("link indicator mismatch");
    pol_default_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !duplex_indicator_remap && !speed_100)
        |=> (polarity_duplex_indicator_n == !$past(polarity_good)))
        else $error("polarity indicator mismatch at 10 Mb/s");
    dup_remap_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && duplex_indicator_remap)
        |=> (polarity_duplex_indicator_n == !$past(full_duplex)))
        else $error("duplex indicator mismatch under remap");
    col_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce |=> (collision_indicator_n == !$past(collision_active)))
        else $error("collision indicator mismatch");
    freeze_ce_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ce |=> $stable(ind_reg))
        else $error("indicators changed with clock enable low");
    freeze_stretch_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ce |=> ($stable(tx_on) && $stable(rx_on)))
        else $error("stretchers moved with clock enable low");
    dup_100_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && speed_100 && !duplex_indicator_remap)
        |=> (polarity_duplex_indicator_n == !$past(full_duplex)))
        else $error("duplex indicator mismatch at 100 Mb/s");
    remap_over_tx_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && tx_indicator_remap && tx_active && !disconnect_state)
        |=> tx_activity_indicator_n)
        else $error("transmit traffic shown while remapped");
    col_in_duplex_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && full_duplex) |=> (collision_indicator_n == !$past(collision_active)))
        else $error("collision indicator altered in full duplex");

    // ----------------------------------------
    // hold time checks
    // ----------------------------------------
    // low for idle counts 1..N after the last activity, high from N+1 on
    tx_hold_on_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!tx_remap_seen_reg && tx_idle_reg != '0 && tx_idle_reg <= HOLD_LAST)
        |-> !tx_activity_indicator_n)
        else $error("tx indicator released before the hold time");
    tx_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!tx_remap_seen_reg && tx_idle_reg > HOLD_LAST) |-> tx_activity_indicator_n)
        else $error("tx indicator held past the hold time");
    rx_hold_on_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rx_idle_reg != '0 && rx_idle_reg <= HOLD_LAST)
        |-> !rx_activity_indicator_n)
        else $error("rx indicator released before the hold time");
    rx_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rx_idle_reg > HOLD_LAST) |-> rx_activity_indicator_n)
        else $error("rx indicator held past the hold time");

    cov_tx_pulse: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(tx_active) ##1 $fell(tx_active));
    cov_tx_remap: cover property (@(posedge clk) disable iff (!rst_n)
        tx_indicator_remap && disconnect_state);
    cov_dup_100: cover property (@(posedge clk) disable iff (!rst_n)
        speed_100 && full_duplex && !duplex_indicator_remap);
    cov_collision: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(collision_indicator_n));
endmodule : psl_led_driver
`default_nettype wire

// ==== rtl/psl_pkg.sv ====
// package: constants for the phy status indicator driver
`default_nettype none
package psl_pkg;
    // ----------------------------------------
    // configuration bit positions and indicator reset value
    // ----------------------------------------
    localparam int unsigned CFG_TX_REMAP_BIT     = 2;
    localparam int unsigned CFG_DUPLEX_REMAP_BIT = 1;
    localparam int unsigned PHYAD_DISC_BIT       = 5;
    localparam logic [4:0]  IND_RESET_VALUE      = 5'h1f;
    // ----------------------------------------
    // stretch timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned STRETCH_MS     = 50;
    localparam int unsigned STRETCH_CYCLES = (STRETCH_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned STRETCH_W      = 20;
endpackage : psl_pkg
`default_nettype wire

// ==== rtl/psl_stretch.sv ====
// module: retriggerable monostable that stretches an activity level
`timescale 1ns/1ps
`default_nettype none
module psl_stretch #(
    parameter int unsigned CW     = psl_pkg::STRETCH_W,
    parameter int unsigned CYCLES = psl_pkg::STRETCH_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic act,
    output var  logic on
);
    import psl_pkg::*;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          on_reg;
    logic          on_next;

    // ----------------------------------------
    // counter: reloads while active, so every new event restarts the hold
    // ----------------------------------------
    always_comb begin
        cnt_next = cnt_reg;
        if (act) begin
            cnt_next = CW'(CYCLES);
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - CW'(1);
        end
        on_next = act || (cnt_reg > CW'(1));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            on_reg  <= 1'b0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
            on_reg  <= on_next;
        end
    end

    assign on = on_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    hold_after_act_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && act) |=> (cnt_reg == CW'(CYCLES)))
        else $error("stretch counter not reloaded by activity");
    on_follows_act_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && act) |=> on_reg)
        else $error("stretched output not on after activity");
    off_when_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !act && cnt_reg <= CW'(1)) |=> !on_reg)
        else $error("stretched output stuck on");
    cov_stretch_end: cover property (@(posedge clk) disable iff (!rst_n) $fell(on_reg));
endmodule : psl_stretch
`default_nettype wire

// ==== tb/psl_led_monitor.sv ====
// partner model: lamp or management monitor reading the five active-low indicators
`timescale 1ns/1ps
`default_nettype none
module psl_led_monitor (
    input  wire logic [4:0] ind_n,
    input  wire logic       full_duplex,
    output var  logic [4:0] lit
);
    // ----------------------------------------
    // lamp state as the monitor reads it
    // ----------------------------------------
    always_comb begin
        lit    = ~ind_n;
        // collision level means nothing in full duplex, so it is discarded here
        lit[0] = ~ind_n[0] & ~full_duplex;
    end
endmodule : psl_led_monitor
`default_nettype wire

// ==== tb/tb.sv ====
// testbench: self-checking bench of the phy status indicator driver
`timescale 1ns/1ps
`default_nettype none
module tb;
    import psl_pkg::*;
    // short stretch keeps the run brief; expectations below follow from it
    localparam int unsigned N = 8;
    logic       clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic       tx = 1'b0, crs = 1'b0, lnk = 1'b0, pol = 1'b0, fd = 1'b0, spd = 1'b0;
    logic       col = 1'b0, txr = 1'b0, dxr = 1'b0, disc = 1'b0;
    wire  [4:0] ind;
    wire  [4:0] lit;
    int         num_errors = 0, num_checks = 0, cyc = 0;
    // ----------------------------------------
    // design and partner
    // ----------------------------------------
    psl_led_driver #(.STRETCH_CYCLES(N)) psl_led_driver_i (.clk(clk), .rst_n(rst_n), .ce(ce),
        .tx_active(tx), .crs_active(crs), .link_good(lnk), .polarity_good(pol),
        .full_duplex(fd), .speed_100(spd), .collision_active(col), .tx_indicator_remap(txr),
        .duplex_indicator_remap(dxr), .disconnect_state(disc),
        .tx_activity_indicator_n(ind[4]), .rx_activity_indicator_n(ind[3]),
        .link_good_indicator_n(ind[2]), .polarity_duplex_indicator_n(ind[1]),
        .collision_indicator_n(ind[0]));
    psl_led_monitor psl_led_monitor_i (.ind_n(ind), .full_duplex(fd), .lit(lit));
    initial forever #50 clk = ~clk;
    // a hang ends the run as a failure
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %b seen %b", name, exp, seen);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : wt
    task automatic act(input logic rx, input logic v);
        @(posedge clk);
        if (rx) crs <= v;
        else tx <= v;
    endtask : act
    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_steady;
        logic [5:0] v;
        for (int i = 0; i < 64; i++) begin
            v = i[5:0];
            @(posedge clk);
            {dxr, spd, fd, pol, lnk, col} <= v;
            wt(2);
            chk("link", ind[2], ~v[1]);
            chk("pol_dup", ind[1], (v[5] | v[4]) ? ~v[3] : ~v[2]);
            chk("coll", ind[0], ~v[0]);
            chk("mon_coll", lit[0], v[0] & ~v[3]);
            chk("mon_link", lit[2], v[1]);
            chk("mon_pd", lit[1], (v[5] | v[4]) ? v[3] : v[2]);
        end
    endtask : t_steady
    // one-cycle burst, then a second burst inside the stretch window
    task automatic t_stretch(input logic rx);
        act(rx, 1'b1);
        act(rx, 1'b0);
        wt(2);
        chk("act_on", rx ? ind[3] : ind[4], 1'b0);
        chk("mon_on", rx ? lit[3] : lit[4], 1'b1);
        wt(3);
        chk("act_held", rx ? ind[3] : ind[4], 1'b0);
        act(rx, 1'b1);
        act(rx, 1'b0);
        wt(7);
        chk("act_restart", rx ? ind[3] : ind[4], 1'b0);
        wt(12);
        chk("act_off", rx ? ind[3] : ind[4], 1'b1);
    endtask : t_stretch
    // remapped tx output follows the disconnect bit, even with traffic present
    task automatic t_remap;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {tx, disc} <= i[1:0];
            txr <= 1'b1;
            wt(3);
            chk("tx_remap", ind[4], ~i[0]);
            chk("mon_tx", lit[4], i[0]);
        end
        @(posedge clk);
        txr <= 1'b0;
        tx  <= 1'b0;
        wt(2);
        chk("tx_unmapped", ind[4], 1'b0);
    endtask : t_remap
    // with the clock enable low nothing moves
    task automatic t_freeze;
        @(posedge clk);
        ce  <= 1'b0;
        lnk <= 1'b0;
        wt(3);
        chk("link_frozen", ind[2], 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        wt(2);
        chk("link_thawed", ind[2], 1'b1);
    endtask : t_freeze
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        wt(4);
        for (int b = 0; b < 5; b++) chk("reset_ind", ind[b], IND_RESET_VALUE[b]);
        @(posedge clk);
        rst_n <= 1'b1;
        t_steady();
        t_freeze();
        t_stretch(1'b0);
        t_stretch(1'b1);
        t_remap();
        results();
    end
endmodule : tb
`default_nettype wire
